// [src/tccu_pkg.sv]
// Constants shared by the timer capture/compare unit.
// Assumes a byte-wide internal bus with a 6-bit register address.
package tccu_pkg;

    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [5:0] OFF_CAP1_HI = 6'h00;
    localparam logic [5:0] OFF_CAP1_LO = 6'h01;
    localparam logic [5:0] OFF_CAP2_HI = 6'h02;
    localparam logic [5:0] OFF_CAP2_LO = 6'h03;
    localparam logic [5:0] OFF_CAP3_HI = 6'h04;
    localparam logic [5:0] OFF_CAP3_LO = 6'h05;
    localparam logic [5:0] OFF_CMP1_HI = 6'h06;
    localparam logic [5:0] OFF_CMP1_LO = 6'h07;
    localparam logic [5:0] OFF_CMP2_HI = 6'h08;
    localparam logic [5:0] OFF_CMP2_LO = 6'h09;
    localparam logic [5:0] OFF_CMP3_HI = 6'h0A;
    localparam logic [5:0] OFF_CMP3_LO = 6'h0B;
    localparam logic [5:0] OFF_CMP4_HI = 6'h0C;
    localparam logic [5:0] OFF_CMP4_LO = 6'h0D;
    localparam logic [5:0] OFF_SHARED_HI = 6'h0E;
    localparam logic [5:0] OFF_SHARED_LO = 6'h0F;
    localparam logic [5:0] OFF_COUNT_HI = 6'h10;
    localparam logic [5:0] OFF_COUNT_LO = 6'h11;
    localparam logic [5:0] OFF_FORCE = 6'h12;
    localparam logic [5:0] OFF_MMASK = 6'h13;
    localparam logic [5:0] OFF_MDATA = 6'h14;
    localparam logic [5:0] OFF_PINCTL = 6'h15;
    localparam logic [5:0] OFF_EDGECTL = 6'h16;
    localparam logic [5:0] OFF_CONFIG = 6'h17;
    localparam logic [5:0] OFF_FLAGS = 6'h18;
    localparam logic [5:0] OFF_MASKS = 6'h19;

    // ------------------------------------------------------------
    // Fields, reset values, counts
    // ------------------------------------------------------------
    localparam int CFG_CAP4_SEL_BIT = 2;
    localparam int NUM_CMP = 5;
    localparam int NUM_CAP = 4;
    localparam logic [15:0] CMP_RESET = 16'hFFFF;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [7:0] UPPER_FIVE = 8'hF8;
    localparam logic [15:0] COUNT_ONE = 16'h0001;

    localparam logic [1:0] ACT_OFF = 2'h0;
    localparam logic [1:0] ACT_TOGGLE = 2'h1;
    localparam logic [1:0] ACT_LOW = 2'h2;
    localparam logic [1:0] ACT_HIGH = 2'h3;

endpackage : tccu_pkg

// [src/tccu_cmp_if.sv]
// Link between the unit's top and one compare channel.
// Assumes both ends run on clk_sys.
`timescale 1ns/1ps
interface tccu_cmp_if;
    logic wr_hi;
    logic wr_lo;
    logic [7:0] wdata;
    logic ld;
    logic [15:0] ld_data;
    logic [15:0] count;
    logic enable_cmp;
    logic [15:0] value;
    logic match;

    modport owner (
        output wr_hi,
        output wr_lo,
        output wdata,
        output ld,
        output ld_data,
        output count,
        output enable_cmp,
        input value,
        input match
    );

    modport chan (
        input wr_hi,
        input wr_lo,
        input wdata,
        input ld,
        input ld_data,
        input count,
        input enable_cmp,
        output value,
        output match
    );
endinterface : tccu_cmp_if

// [src/tccu_cmp_chan.sv]
// One 16-bit compare register with its comparator.
// Assumes the owner gives byte writes, a parallel load and the count.
`timescale 1ns/1ps
module tccu_cmp_chan (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    tccu_cmp_if.chan cif
);
    logic [15:0] value_q;
    logic inh_q;

    // ------------------------------------------------------------
    // Storage, usable whether or not compares are wanted
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            value_q <= tccu_pkg::CMP_RESET;
        end
        else if (ce)
        begin
            if (cif.ld)
            begin
                value_q <= cif.ld_data;
            end
            else
            begin
                if (cif.wr_hi)
                begin
                    value_q[15:8] <= cif.wdata;
                end
                if (cif.wr_lo)
                begin
                    value_q[7:0] <= cif.wdata;
                end
            end
        end
    end

    // Half-written value must not match in the cycle after the high byte
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            inh_q <= 1'b0;
        end
        else if (ce)
        begin
            inh_q <= cif.wr_hi;
        end
    end

    assign cif.value = value_q;
    assign cif.match = cif.enable_cmp && !inh_q && (value_q == cif.count);

endmodule : tccu_cmp_chan

// [src/tccu_top.sv]
// Timer capture/compare unit: free-running counter, captures, compares.
// Assumes one bus access per enabled clock, inputs synchronous to clk_sys.
`timescale 1ns/1ps
// What this block does
// - Capture copies full 16-bit count at once
// - Captured count is stable, not mid-increment
// - Captures one to three survive reset, host reads bytes only
// - High-byte read delays capture one cycle, keeps it
// - Shared pair is capture four or compare five
// - Comparators one to four, and five when capture-four clear, check count every bus cycle
// - Reset loads all compare registers with ones
// - Match sets flag; mask enables interrupt request
// - Pin action on every match, flag regardless
// - Master match drives masked data onto pins
// - Master mask/data low three bits read zero
// - High-byte write suppresses compare one cycle
// - Unused compare register is plain storage
// - Force bit does action, sets no flag
// - Forced action lands at next count transition
// - Count high read buffers low byte coherently
// - Mode/level pair: off, toggle, low, high
// - Fifth compare pin only when capture-four clear
// - Flags cleared only by writing ones
// - Edge select: off, rise, fall, any
module tccu_top (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    input wire logic bus_rd,
    input wire logic bus_wr,
    input wire logic [5:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    output logic [7:0] bus_rdata,
    input wire logic [3:0] cap_pin,
    output logic [4:0] port_pins_seven_to_three,
    output logic [4:0] port_pins_oe,
    output logic irq
);
    logic [15:0] free_running_count_q;
    logic [15:0] cap_q [0:2];
    logic [3:0] cap_prev_q;
    logic [3:0] cap_pend_q;
    logic [3:0] cap_blk_q;
    logic [3:0] cap_hit;
    logic [3:0] cap_xfer;
    logic [7:0] edge_ctl_q;
    logic capture_four_select_q;
    logic [7:0] first_timer_flags_q;
    logic [7:0] first_timer_masks_q;
    logic [7:0] flag_set;
    logic [4:0] force_bits_q;
    logic [4:0] cmp_match;
    logic [4:0] cmp_act;
    logic [7:0] master_compare_mask_q;
    logic [7:0] master_compare_data_q;
    logic [7:0] compare_pin_action_control_q;
    logic [4:0] pin_q;
    logic [4:0] pin_d;
    logic [7:0] lo_buf_q;
    logic lo_buf_vld_q;
    logic [7:0] rdata_d;
    logic wr;
    logic rd;

    assign wr = ce && bus_wr;
    assign rd = ce && bus_rd;

    // ------------------------------------------------------------
    // Free-running counter
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            free_running_count_q <= 16'h0000;
        end
        else if (ce)
        begin
            free_running_count_q <= free_running_count_q + tccu_pkg::COUNT_ONE;
        end
    end

    // ------------------------------------------------------------
    // Compare channels: 0..3 plain, 4 the shared pair
    // ------------------------------------------------------------
    tccu_cmp_if cif [0:4] ();

    generate
        for (genvar k = 0; k < tccu_pkg::NUM_CMP; k++)
        begin : g_cmp
            localparam logic [5:0] HI_OFF = tccu_pkg::OFF_CMP1_HI + 6'(2 * k);
            localparam logic [5:0] LO_OFF = tccu_pkg::OFF_CMP1_LO + 6'(2 * k);
            // Shared pair ignores writes while it serves as a capture
            logic wr_ok;
            assign wr_ok = (k != 4) || !capture_four_select_q;
            assign cif[k].wr_hi = wr && wr_ok && (bus_addr == HI_OFF);
            assign cif[k].wr_lo = wr && wr_ok && (bus_addr == LO_OFF);
            assign cif[k].wdata = bus_wdata;
            assign cif[k].count = free_running_count_q;
            assign cif[k].enable_cmp = wr_ok;
            assign cif[k].ld = (k == 4) && cap_xfer[3];
            assign cif[k].ld_data = free_running_count_q;
            assign cmp_match[k] = cif[k].match;
            tccu_cmp_chan u_chan (
                .clk_sys(clk_sys),
                .rst(rst),
                .ce(ce),
                .cif(cif[k])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Capture edge detection and transfer
    // ------------------------------------------------------------
    function automatic logic edge_hit(input logic [1:0] sel, input logic now, input logic prev);
        case (sel)
            2'h1: edge_hit = now && !prev;
            2'h2: edge_hit = !now && prev;
            2'h3: edge_hit = now != prev;
            default: edge_hit = 1'b0;
        endcase
    endfunction : edge_hit

    always_comb
    begin
        for (int i = 0; i < tccu_pkg::NUM_CAP; i++)
        begin
            cap_hit[i] = edge_hit(edge_ctl_q[7 - 2 * i -: 2], cap_pin[i], cap_prev_q[i]);
        end
        cap_hit[3] = cap_hit[3] && capture_four_select_q;
        // A blocked capture waits a cycle instead of vanishing
        cap_xfer = (cap_hit | cap_pend_q) & ~cap_blk_q;
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            cap_prev_q <= 4'h0;
            cap_pend_q <= 4'h0;
            cap_blk_q <= 4'h0;
        end
        else if (ce)
        begin
            cap_prev_q <= cap_pin;
            cap_pend_q <= (cap_hit | cap_pend_q) & cap_blk_q;
            cap_blk_q[0] <= bus_rd && (bus_addr == tccu_pkg::OFF_CAP1_HI);
            cap_blk_q[1] <= bus_rd && (bus_addr == tccu_pkg::OFF_CAP2_HI);
            cap_blk_q[2] <= bus_rd && (bus_addr == tccu_pkg::OFF_CAP3_HI);
            cap_blk_q[3] <= bus_rd && (bus_addr == tccu_pkg::OFF_SHARED_HI);
        end
    end

    // No reset: captured values survive it
    always_ff @(posedge clk_sys)
    begin
        if (ce)
        begin
            for (int i = 0; i < 3; i++)
            begin
                if (cap_xfer[i])
                begin
                    // Counter register holds this cycle's stable value
                    cap_q[i] <= free_running_count_q;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            edge_ctl_q <= tccu_pkg::BYTE_ZERO;
            capture_four_select_q <= 1'b0;
            first_timer_masks_q <= tccu_pkg::BYTE_ZERO;
            master_compare_mask_q <= tccu_pkg::BYTE_ZERO;
            master_compare_data_q <= tccu_pkg::BYTE_ZERO;
            compare_pin_action_control_q <= tccu_pkg::BYTE_ZERO;
        end
        else if (wr)
        begin
            case (bus_addr)
                tccu_pkg::OFF_EDGECTL: edge_ctl_q <= bus_wdata;
                tccu_pkg::OFF_CONFIG:
                    capture_four_select_q <= bus_wdata[tccu_pkg::CFG_CAP4_SEL_BIT];
                tccu_pkg::OFF_MASKS: first_timer_masks_q <= bus_wdata;
                tccu_pkg::OFF_MMASK:
                    master_compare_mask_q <= bus_wdata & tccu_pkg::UPPER_FIVE;
                tccu_pkg::OFF_MDATA:
                    master_compare_data_q <= bus_wdata & tccu_pkg::UPPER_FIVE;
                tccu_pkg::OFF_PINCTL: compare_pin_action_control_q <= bus_wdata;
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Flags and interrupt request
    // ------------------------------------------------------------
    always_comb
    begin
        flag_set[7] = cmp_match[0];
        flag_set[6] = cmp_match[1];
        flag_set[5] = cmp_match[2];
        flag_set[4] = cmp_match[3];
        flag_set[3] = cmp_match[4] || cap_xfer[3];
        flag_set[2] = cap_xfer[0];
        flag_set[1] = cap_xfer[1];
        flag_set[0] = cap_xfer[2];
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            first_timer_flags_q <= tccu_pkg::BYTE_ZERO;
        end
        else if (ce)
        begin
            // Set wins over a simultaneous clear
            if (bus_wr && (bus_addr == tccu_pkg::OFF_FLAGS))
            begin
                first_timer_flags_q <= (first_timer_flags_q & ~bus_wdata) | flag_set;
            end
            else
            begin
                first_timer_flags_q <= first_timer_flags_q | flag_set;
            end
        end
    end

    assign irq = |(first_timer_flags_q & first_timer_masks_q);

    // ------------------------------------------------------------
    // Forced compares
    // ------------------------------------------------------------
    // Counter moves on every enabled cycle, so the next one is the transition
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            force_bits_q <= 5'h00;
        end
        else if (ce)
        begin
            if (bus_wr && (bus_addr == tccu_pkg::OFF_FORCE))
            begin
                force_bits_q <= bus_wdata[7:3];
            end
            else
            begin
                force_bits_q <= 5'h00;
            end
        end
    end

    // Bit 4 of the vector is channel one; flags see only true matches
    assign cmp_act = cmp_match | {force_bits_q[0], force_bits_q[1], force_bits_q[2],
                                  force_bits_q[3], force_bits_q[4]};

    // ------------------------------------------------------------
    // Pin actions; pin index 4 is pin seven, index 0 pin three
    // ------------------------------------------------------------
    always_comb
    begin
        pin_d = pin_q;
        for (int k = 1; k < tccu_pkg::NUM_CMP; k++)
        begin
            if (cmp_act[k] && ((k != 4) || !capture_four_select_q))
            begin
                case (compare_pin_action_control_q[9 - 2 * k -: 2])
                    tccu_pkg::ACT_TOGGLE: pin_d[4 - k] = !pin_q[4 - k];
                    tccu_pkg::ACT_LOW: pin_d[4 - k] = 1'b0;
                    tccu_pkg::ACT_HIGH: pin_d[4 - k] = 1'b1;
                    default: ;
                endcase
            end
        end
        // Master channel applied last, so it wins on shared pins
        if (cmp_act[0])
        begin
            for (int j = 0; j < 5; j++)
            begin
                if (master_compare_mask_q[3 + j])
                begin
                    pin_d[j] = master_compare_data_q[3 + j];
                end
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            pin_q <= 5'h00;
        end
        else if (ce)
        begin
            pin_q <= pin_d;
        end
    end

    assign port_pins_seven_to_three = pin_q;

    always_comb
    begin
        port_pins_oe[4] = master_compare_mask_q[7];
        for (int k = 1; k < tccu_pkg::NUM_CMP; k++)
        begin
            port_pins_oe[4 - k] = master_compare_mask_q[7 - k] ||
                (compare_pin_action_control_q[9 - 2 * k -: 2] != tccu_pkg::ACT_OFF);
        end
        port_pins_oe[0] = port_pins_oe[0] && !capture_four_select_q;
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            lo_buf_q <= tccu_pkg::BYTE_ZERO;
            lo_buf_vld_q <= 1'b0;
        end
        else if (ce)
        begin
            lo_buf_vld_q <= bus_rd && (bus_addr == tccu_pkg::OFF_COUNT_HI);
            if (bus_rd && (bus_addr == tccu_pkg::OFF_COUNT_HI))
            begin
                lo_buf_q <= free_running_count_q[7:0];
            end
        end
    end

    always_comb
    begin
        case (bus_addr)
            tccu_pkg::OFF_CAP1_HI: rdata_d = cap_q[0][15:8];
            tccu_pkg::OFF_CAP1_LO: rdata_d = cap_q[0][7:0];
            tccu_pkg::OFF_CAP2_HI: rdata_d = cap_q[1][15:8];
            tccu_pkg::OFF_CAP2_LO: rdata_d = cap_q[1][7:0];
            tccu_pkg::OFF_CAP3_HI: rdata_d = cap_q[2][15:8];
            tccu_pkg::OFF_CAP3_LO: rdata_d = cap_q[2][7:0];
            tccu_pkg::OFF_CMP1_HI: rdata_d = cif[0].value[15:8];
            tccu_pkg::OFF_CMP1_LO: rdata_d = cif[0].value[7:0];
            tccu_pkg::OFF_CMP2_HI: rdata_d = cif[1].value[15:8];
            tccu_pkg::OFF_CMP2_LO: rdata_d = cif[1].value[7:0];
            tccu_pkg::OFF_CMP3_HI: rdata_d = cif[2].value[15:8];
            tccu_pkg::OFF_CMP3_LO: rdata_d = cif[2].value[7:0];
            tccu_pkg::OFF_CMP4_HI: rdata_d = cif[3].value[15:8];
            tccu_pkg::OFF_CMP4_LO: rdata_d = cif[3].value[7:0];
            tccu_pkg::OFF_SHARED_HI: rdata_d = cif[4].value[15:8];
            tccu_pkg::OFF_SHARED_LO: rdata_d = cif[4].value[7:0];
            tccu_pkg::OFF_COUNT_HI: rdata_d = free_running_count_q[15:8];
            tccu_pkg::OFF_COUNT_LO:
                rdata_d = lo_buf_vld_q ? lo_buf_q : free_running_count_q[7:0];
            tccu_pkg::OFF_MMASK: rdata_d = master_compare_mask_q;
            tccu_pkg::OFF_MDATA: rdata_d = master_compare_data_q;
            tccu_pkg::OFF_PINCTL: rdata_d = compare_pin_action_control_q;
            tccu_pkg::OFF_EDGECTL: rdata_d = edge_ctl_q;
            tccu_pkg::OFF_CONFIG:
                rdata_d = {5'h00, capture_four_select_q, 2'h0};
            tccu_pkg::OFF_FLAGS: rdata_d = first_timer_flags_q;
            tccu_pkg::OFF_MASKS: rdata_d = first_timer_masks_q;
            default: rdata_d = tccu_pkg::BYTE_ZERO; // Force register reads zero too
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            bus_rdata <= tccu_pkg::BYTE_ZERO;
        end
        else if (rd)
        begin
            bus_rdata <= rdata_d;
        end
    end

endmodule : tccu_top

// [tb/tccu_host.sv]
// Host bus model: one byte access per clock, issued just after a rising edge.
// Assumes calls start one nanosecond after a rising edge.
`timescale 1ns/1ps
module tccu_host (
    input wire logic clk_sys,
    output logic bus_rd,
    output logic bus_wr,
    output logic [5:0] bus_addr,
    output logic [7:0] bus_wdata,
    input wire logic [7:0] bus_rdata
);
    initial
    begin
        bus_rd = 1'b0;
        bus_wr = 1'b0;
        bus_addr = 6'h3F;
        bus_wdata = 8'h00;
    end

    // Strobe stays up after return so hi/lo pairs go back to back
    task acc(input logic rd, input logic [5:0] a, input logic [7:0] d, output logic [7:0] q);
        bus_rd = rd;
        bus_wr = !rd;
        bus_addr = a;
        bus_wdata = d;
        @(posedge clk_sys);
        #1;
        q = bus_rdata;
    endtask : acc

    // Released lines show the inverse
    task idle(input int n);
        bus_rd = 1'b0;
        bus_wr = 1'b0;
        bus_addr = ~bus_addr;
        bus_wdata = ~bus_wdata;
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : idle
endmodule : tccu_host

// [tb/tccu_assertions.sv]
// Port-level checks of the capture/compare unit, bound to its top.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
module tccu_checker (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    input wire logic bus_rd,
    input wire logic bus_wr,
    input wire logic [5:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    input wire logic [7:0] bus_rdata,
    input wire logic [3:0] cap_pin,
    input wire logic [4:0] port_pins_seven_to_three,
    input wire logic [4:0] port_pins_oe,
    input wire logic irq
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    logic [15:0] cnt_q;
    logic [7:0] cnt_hi, cnt_lo, mask_q, cfg_q, ctl_q, ien_q;
    assign cnt_hi = cnt_q[15:8];
    assign cnt_lo = cnt_q[7:0];

    // ------------------------------------------------------------
    // Shadow copies of the count and of written control registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            cnt_q <= 16'h0000;
        else if (ce)
            cnt_q <= cnt_q + 16'h0001;
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            mask_q <= 8'h00;
            cfg_q <= 8'h00;
            ctl_q <= 8'h00;
            ien_q <= 8'h00;
        end
        else if (ce && bus_wr)
        begin
            if (bus_addr == tccu_pkg::OFF_MMASK)
                mask_q <= bus_wdata;
            if (bus_addr == tccu_pkg::OFF_CONFIG)
                cfg_q <= bus_wdata;
            if (bus_addr == tccu_pkg::OFF_PINCTL)
                ctl_q <= bus_wdata;
            if (bus_addr == tccu_pkg::OFF_MASKS)
                ien_q <= bus_wdata;
        end
    end

    sequence s_cnt_hi;
        ce && bus_rd && bus_addr == tccu_pkg::OFF_COUNT_HI;
    endsequence
    sequence s_cnt_lo;
        ce && bus_rd && bus_addr == tccu_pkg::OFF_COUNT_LO;
    endsequence

    a_count_hi_byte: assert property (s_cnt_hi |=> bus_rdata == $past(cnt_hi))
        else $error("count high byte differs from the count");
    a_count_lo_buf: assert property (s_cnt_hi ##1 s_cnt_lo |=> bus_rdata == $past(cnt_lo, 2))
        else $error("count low byte not taken at the high read");
    a_force_reads_zero: assert property (ce && bus_rd && bus_addr == tccu_pkg::OFF_FORCE
        |=> bus_rdata == 8'h00) else $error("force register read not zero");
    a_master_low_zero: assert property (ce && bus_rd && (bus_addr == tccu_pkg::OFF_MMASK
        || bus_addr == tccu_pkg::OFF_MDATA) |=> bus_rdata[2:0] == 3'h0)
        else $error("master mask or data low bits not zero");
    a_pin7_oe_mask: assert property (port_pins_oe[4] == mask_q[7])
        else $error("top pin enable does not follow master mask");
    a_pin3_oe_off: assert property (cfg_q[2] && !mask_q[3] |-> !port_pins_oe[0])
        else $error("fifth compare pin driven in capture mode");
    a_ch2_oe_on: assert property (ctl_q[7:6] != 2'h0 |-> port_pins_oe[3])
        else $error("second compare pin not driven with an action set");
    a_irq_needs_en: assert property (irq |-> ien_q != 8'h00)
        else $error("interrupt request with all enables clear");
endmodule : tccu_checker

bind tccu_top tccu_checker i_tccu_checker (.clk_sys(clk_sys), .rst(rst), .ce(ce),
    .bus_rd(bus_rd), .bus_wr(bus_wr), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_rdata(bus_rdata), .cap_pin(cap_pin), .port_pins_seven_to_three(port_pins_seven_to_three),
    .port_pins_oe(port_pins_oe), .irq(irq));

// [tb/tb.sv]
// Self-checking bench: register tests built from host bus calls.
// Assumes the host model drives the bus and the checker is bound.
`timescale 1ns/1ps
module tb;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic bus_rd, bus_wr, irq;
    logic [5:0] bus_addr;
    logic [7:0] bus_wdata, bus_rdata, q;
    logic [3:0] cap_pin = 4'h0;
    logic [4:0] pins, pins_oe;
    logic [15:0] cnt, v;
    int fails = 0;
    int n_tests = 0;

    always #12.5 clk_sys = ~clk_sys;
    // Count mirror, frozen while ce is low
    always @(posedge clk_sys) cnt <= rst ? 16'h0000 : cnt + 16'(ce);

    tccu_top i_tccu_top (.clk_sys(clk_sys), .rst(rst), .ce(ce), .bus_rd(bus_rd),
        .bus_wr(bus_wr), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
        .cap_pin(cap_pin), .port_pins_seven_to_three(pins), .port_pins_oe(pins_oe), .irq(irq));
    tccu_host i_tccu_host (.clk_sys(clk_sys), .bus_rd(bus_rd), .bus_wr(bus_wr),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata));

    // ------------------------------------------------------------
    // Access and compare tasks
    // ------------------------------------------------------------
    task summarize;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : summarize

    task chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            fails++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task wr(input logic [5:0] a, input logic [7:0] d);
        i_tccu_host.acc(1'b0, a, d, q);
    endtask : wr

    task rdc(input logic [5:0] a, input logic [7:0] exp);
        i_tccu_host.acc(1'b1, a, 8'h00, q);
        chk(q, exp);
    endtask : rdc

    // Schedules a match twenty counts ahead; low byte is written second
    task arm(input logic [5:0] hi);
        v = cnt + 16'h0014;
        wr(hi, v[15:8]);
        wr(hi + 6'h01, v[7:0]);
        i_tccu_host.idle(1);
    endtask : arm

    task wait_pin(input int idx, input logic val);
        int k;
        k = 0;
        while (pins[idx] !== val && k < 200)
        begin
            @(posedge clk_sys);
            #1;
            k++;
        end
        chk({7'h00, pins[idx]}, {7'h00, val});
        if (k == 200)
            summarize();
    endtask : wait_pin

    initial
    begin
        repeat (12) @(posedge clk_sys);
        #1;
        rst = 1'b0;
        for (int a = 6; a < 16; a++) rdc(a[5:0], 8'hFF);
        wr(tccu_pkg::OFF_CMP4_HI, 8'h12);
        wr(tccu_pkg::OFF_CMP4_LO, 8'h34);
        rdc(tccu_pkg::OFF_CMP4_HI, 8'h12);
        rdc(tccu_pkg::OFF_CMP4_LO, 8'h34);
        wr(tccu_pkg::OFF_CONFIG, 8'h04);
        wr(tccu_pkg::OFF_SHARED_HI, 8'h00);
        rdc(tccu_pkg::OFF_SHARED_HI, 8'hFF);
        wr(tccu_pkg::OFF_CONFIG, 8'h00);
        wr(tccu_pkg::OFF_SHARED_HI, 8'h55);
        rdc(tccu_pkg::OFF_SHARED_HI, 8'h55);
        wr(tccu_pkg::OFF_MMASK, 8'hFF);
        rdc(tccu_pkg::OFF_MMASK, 8'hF8);
        wr(tccu_pkg::OFF_MDATA, 8'hFF);
        rdc(tccu_pkg::OFF_MDATA, 8'hF8);
        wr(tccu_pkg::OFF_MMASK, 8'h00);
        ce = 1'b0;
        i_tccu_host.idle(3);
        ce = 1'b1;
        v = cnt;
        rdc(tccu_pkg::OFF_COUNT_HI, v[15:8]);
        rdc(tccu_pkg::OFF_COUNT_LO, v[7:0]);
        // Compare matches: high, then low and toggle with the flag left set
        wr(tccu_pkg::OFF_MASKS, 8'h40);
        wr(tccu_pkg::OFF_PINCTL, 8'hC0);
        arm(tccu_pkg::OFF_CMP2_HI);
        wait_pin(3, 1'b1);
        chk({7'h00, irq}, 8'h01);
        rdc(tccu_pkg::OFF_FLAGS, 8'h40);
        wr(tccu_pkg::OFF_FLAGS, 8'h00);
        rdc(tccu_pkg::OFF_FLAGS, 8'h40);
        wr(tccu_pkg::OFF_PINCTL, 8'h80);
        arm(tccu_pkg::OFF_CMP2_HI);
        wait_pin(3, 1'b0);
        wr(tccu_pkg::OFF_PINCTL, 8'h40);
        arm(tccu_pkg::OFF_CMP2_HI);
        wait_pin(3, 1'b1);
        wr(tccu_pkg::OFF_FLAGS, 8'h40);
        rdc(tccu_pkg::OFF_FLAGS, 8'h00);
        // Match due in the cycle after a high-byte write must not fire
        wr(tccu_pkg::OFF_PINCTL, 8'h30);
        v = cnt + 16'h0002;
        wr(tccu_pkg::OFF_CMP3_LO, v[7:0]);
        wr(tccu_pkg::OFF_CMP3_HI, v[15:8]);
        i_tccu_host.idle(4);
        chk({7'h00, pins[2]}, 8'h00);
        rdc(tccu_pkg::OFF_FLAGS, 8'h00);
        // Forced high action on a non-toggling channel
        wr(tccu_pkg::OFF_FORCE, 8'h20);
        chk({7'h00, pins[2]}, 8'h00);
        i_tccu_host.idle(1);
        chk({7'h00, pins[2]}, 8'h01);
        rdc(tccu_pkg::OFF_FLAGS, 8'h00);
        rdc(tccu_pkg::OFF_FORCE, 8'h00);
        wr(tccu_pkg::OFF_MMASK, 8'hA0);
        wr(tccu_pkg::OFF_MDATA, 8'h80);
        arm(tccu_pkg::OFF_CMP1_HI);
        wait_pin(4, 1'b1);
        chk({7'h00, pins[2]}, 8'h00);
        wr(tccu_pkg::OFF_FLAGS, 8'hFF);
        // Capture on a rising edge, then one delayed by a high-byte read
        wr(tccu_pkg::OFF_EDGECTL, 8'h40);
        v = cnt;
        cap_pin = 4'h1;
        i_tccu_host.idle(3);
        rdc(tccu_pkg::OFF_CAP1_HI, v[15:8]);
        rdc(tccu_pkg::OFF_CAP1_LO, v[7:0]);
        rdc(tccu_pkg::OFF_FLAGS, 8'h04);
        wr(tccu_pkg::OFF_EDGECTL, 8'hC0);
        i_tccu_host.acc(1'b1, tccu_pkg::OFF_CAP1_HI, 8'h00, q);
        v = cnt + 16'h0001;
        cap_pin = 4'h0;
        i_tccu_host.idle(3);
        rdc(tccu_pkg::OFF_CAP1_HI, v[15:8]);
        rdc(tccu_pkg::OFF_CAP1_LO, v[7:0]);
        summarize();
    end
endmodule : tb
